// ### core/mcalu_core.sv
// Microcore arithmetic logic unit with register file and condition register.
`timescale 1ns/1ps
`default_nettype none

module mcalu_core
    import mcalu_pkg::*;
#(
    parameter int MUL_LATENCY = 32
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic OP_VALID_I,
    input wire mcalu_op_t OP_CODE_I,
    input wire logic [SEL_W-1:0] OP1_SEL_I,
    input wire logic [SEL_W-1:0] OP2_SEL_I,
    input wire logic [SEL_W-1:0] RES_SEL_I,
    input wire logic [IMM_W-1:0] IMM_I,
    input wire logic [1:0] MODE_I,
    input wire logic ACCUM_SIGN_I,
    input wire logic WR_EN_I,
    input wire logic [SEL_W-1:0] WR_SEL_I,
    input wire logic [DATA_W-1:0] WR_DATA_I,
    input wire logic [SEL_W-1:0] RD_SEL_I,
    output logic [DATA_W-1:0] RD_DATA_O,
    output logic [DATA_W-1:0] COND_O,
    output logic [WIDE_W-1:0] PROD_O,
    output logic BUSY_O
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MUL,
        ST_SHIFT
    } mcalu_state_t;

    typedef enum logic [1:0] {
        SK_LOGIC,
        SK_SIGNED,
        SK_WIDE
    } mcalu_skind_t;

    logic [DATA_W-1:0] gpr_q [GPR_N];
    logic [DATA_W-1:0] cond_q;
    logic [WIDE_W-1:0] prod_q;
    logic [DATA_W-1:0] rd_q;
    mcalu_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [WIDE_W-1:0] work_q;
    mcalu_skind_t skind_q;
    logic sright_q;
    logic [SEL_W-1:0] target_q;
    logic mul_imm_q;
    logic busy_q;

    function automatic logic [DATA_W-1:0] negate(input logic [DATA_W-1:0] v);
        negate = DATA_W'(~v + 16'h0001);
    endfunction

    function automatic logic [CNT_W-1:0] limit_count(
        input logic [DATA_W-1:0] v,
        input logic wide
    );
        logic [DATA_W-1:0] lim;
        lim = wide ? 16'h0020 : 16'h0010;
        limit_count = (v > lim) ? CNT_W'(lim) : CNT_W'(v);
    endfunction

    // Issue decode and operand selection.
    wire issue = OP_VALID_I && (state_q == ST_IDLE);
    wire [DATA_W-1:0] op1 = gpr_q[OP1_SEL_I];
    wire [DATA_W-1:0] op2 = gpr_q[OP2_SEL_I];
    wire [DATA_W-1:0] mask = gpr_q[MASK_GPR];
    wire [DATA_W-1:0] imm_ext = DATA_W'(IMM_I);
    mcalu_mode_t mode;
    assign mode = mcalu_mode_t'(cond_q[MODE_HI_BIT:MODE_LO_BIT]);

    wire is_imm_form = (OP_CODE_I == MCALU_ADDI) ||
        (OP_CODE_I == MCALU_SUBI);
    wire [DATA_W-1:0] addend = is_imm_form ?
        DATA_W'(IMM_I[ADD_IMM_W-1:0]) : op2;
    wire is_sub = (OP_CODE_I == MCALU_SUB) || (OP_CODE_I == MCALU_SUBI);
    wire is_addsub = is_sub || (OP_CODE_I == MCALU_ADD) ||
        (OP_CODE_I == MCALU_ADDI);

    wire [DATA_W:0] raw = is_sub ?
        ({1'b0, op1} - {1'b0, addend}) : ({1'b0, op1} + {1'b0, addend});
    wire [DATA_W-1:0] sum = raw[DATA_W-1:0];
    wire carry = raw[DATA_W];
    wire u_high = !is_sub && carry;
    wire u_low = is_sub && carry;
    wire s_same = is_sub ? (op1[15] != addend[15]) : (op1[15] == addend[15]);
    wire s_flip = s_same && (sum[15] != op1[15]);
    wire s_high = s_flip && !op1[15];
    wire s_low = s_flip && op1[15];

    logic [DATA_W-1:0] addsub_res;
    always_comb begin
        addsub_res = sum;
        unique case (mode)
            MCALU_SIGNED_WRAP: addsub_res = sum;
            MCALU_SIGNED_CLAMP: begin
                if (s_high) begin
                    addsub_res = SIGNED_MAX;
                end else if (s_low) begin
                    addsub_res = SIGNED_MIN;
                end
            end
            MCALU_UNSIGNED_WRAP: addsub_res = sum;
            MCALU_UNSIGNED_CLAMP: begin
                if (u_high) begin
                    addsub_res = UNSIGNED_MAX;
                end else if (u_low) begin
                    addsub_res = UNSIGNED_MIN;
                end
            end
        endcase
    end

    // Full 32-bit unsigned product, never overflows.
    wire mul_is_imm = (OP_CODE_I == MCALU_MULI);
    wire [DATA_W-1:0] mul_b = mul_is_imm ? imm_ext : op2;
    wire [WIDE_W-1:0] product = WIDE_W'(op1) * WIDE_W'(mul_b);

    wire op1_neg = op1[DATA_W-1];
    wire [DATA_W-1:0] magnitude = op1_neg ? negate(op1) : op1;
    wire new_sign = ACCUM_SIGN_I ? (cond_q[SIGN_CONV_BIT] ^ op1_neg) :
        op1_neg;
    wire [DATA_W-1:0] signed_back = cond_q[SIGN_CONV_BIT] ? negate(op1) :
        op1;

    logic [DATA_W-1:0] quick_res;
    always_comb begin
        quick_res = op1;
        unique case (OP_CODE_I)
            MCALU_SHR8: quick_res = {8'h00, op1[15:8]};
            MCALU_SHL8: quick_res = {op1[7:0], 8'h00};
            MCALU_SWAP: quick_res = {op1[7:0], op1[15:8]};
            MCALU_NOT: quick_res = ~op1;
            MCALU_AND: quick_res = op1 & mask;
            MCALU_OR: quick_res = op1 | mask;
            MCALU_XOR: quick_res = op1 ^ mask;
            default: quick_res = op1;
        endcase
    end
    wire is_mask_op = (OP_CODE_I == MCALU_NOT) || (OP_CODE_I == MCALU_AND) ||
        (OP_CODE_I == MCALU_OR) || (OP_CODE_I == MCALU_XOR);
    wire is_quick = is_mask_op || (OP_CODE_I == MCALU_SHR8) ||
        (OP_CODE_I == MCALU_SHL8) || (OP_CODE_I == MCALU_SWAP);

    wire is_shift = OP_CODE_I inside {[MCALU_SHR:MCALU_WSHLI]};
    wire shift_right = OP_CODE_I inside {MCALU_SHR, MCALU_SHRI, MCALU_SHRS,
        MCALU_SHRSI, MCALU_WSHR, MCALU_WSHRI};
    wire shift_by_imm = OP_CODE_I inside {MCALU_SHRI, MCALU_SHLI, MCALU_SHRSI,
        MCALU_SHLSI, MCALU_WSHRI, MCALU_WSHLI};
    wire wide_op = OP_CODE_I inside {[MCALU_WSHR:MCALU_WSHLI]};
    mcalu_skind_t shift_kind;
    assign shift_kind = wide_op ? SK_WIDE :
        (OP_CODE_I inside {[MCALU_SHRS:MCALU_SHLSI]}) ? SK_SIGNED : SK_LOGIC;
    wire [DATA_W-1:0] count_src = shift_by_imm ? imm_ext :
        (wide_op ? gpr_q[OP1_SEL_I] : op2);
    wire [CNT_W-1:0] shift_count = limit_count(count_src, wide_op);
    wire [WIDE_W-1:0] shift_init = wide_op ? prod_q : WIDE_W'(op1);

    // One position of the running shift per cycle.
    logic [WIDE_W-1:0] step_val;
    logic step_out;
    always_comb begin
        step_val = work_q;
        step_out = 1'b0;
        unique case (skind_q)
            SK_LOGIC: begin
                step_out = sright_q ? work_q[0] : work_q[15];
                step_val = sright_q ? {17'h0_0000, work_q[15:1]} :
                    {16'h0000, work_q[14:0], 1'b0};
            end
            SK_SIGNED: begin
                step_out = sright_q ? work_q[0] : work_q[14];
                step_val = sright_q ?
                    {16'h0000, work_q[15], work_q[15], work_q[14:1]} :
                    {16'h0000, work_q[15], work_q[13:0], 1'b0};
            end
            SK_WIDE: begin
                step_out = sright_q ? work_q[0] : work_q[31];
                step_val = sright_q ? {1'b0, work_q[31:1]} :
                    {work_q[30:0], 1'b0};
            end
            default: ;
        endcase
    end
    wire last_step = (cnt_q <= 6'h01);
    wire mul_done = (state_q == ST_MUL) && last_step;
    wire shift_done = (state_q == ST_SHIFT) &&
        ((cnt_q == 6'h00) || last_step);
    wire [WIDE_W-1:0] shift_final = (cnt_q == 6'h00) ? work_q : step_val;

    // Sequencer state and working registers.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
            cnt_q <= 6'h00;
            work_q <= 32'h0000_0000;
            skind_q <= SK_LOGIC;
            sright_q <= 1'b0;
            target_q <= 3'h0;
            mul_imm_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (issue && (OP_CODE_I == MCALU_MUL ||
                OP_CODE_I == MCALU_MULI)) begin
            // Product held back for the multiply latency.
            state_q <= ST_MUL;
            cnt_q <= CNT_W'(MUL_LATENCY);
            work_q <= product;
            mul_imm_q <= mul_is_imm;
            busy_q <= 1'b1;
        end else if (issue && is_shift) begin
            state_q <= ST_SHIFT;
            cnt_q <= shift_count;
            work_q <= shift_init;
            skind_q <= shift_kind;
            sright_q <= shift_right;
            target_q <= OP1_SEL_I;
            busy_q <= 1'b1;
        end else if (mul_done || shift_done) begin
            state_q <= ST_IDLE;
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
        end else if (state_q == ST_SHIFT) begin
            work_q <= step_val;
            cnt_q <= CNT_W'(cnt_q - 6'h01);
        end else if (state_q == ST_MUL) begin
            cnt_q <= CNT_W'(cnt_q - 6'h01);
        end
    end

    // Register file writes.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < GPR_N; i++) begin
                gpr_q[i] <= 16'h0000;
            end
        end else if (mul_done && mul_imm_q) begin
            // Immediate product lands in registers six and seven.
            gpr_q[PROD_HI_GPR] <= work_q[31:16];
            gpr_q[PROD_LO_GPR] <= work_q[15:0];
        end else if (shift_done && skind_q != SK_WIDE) begin
            gpr_q[target_q] <= shift_final[DATA_W-1:0];
        end else if (issue && is_addsub) begin
            // Result goes to the named destination.
            gpr_q[RES_SEL_I] <= addsub_res;
        end else if (issue && OP_CODE_I == MCALU_TOINT) begin
            gpr_q[OP1_SEL_I] <= magnitude;
        end else if (issue && OP_CODE_I == MCALU_APPLY_SIGN) begin
            gpr_q[OP1_SEL_I] <= signed_back;
        end else if (issue && is_quick) begin
            gpr_q[OP1_SEL_I] <= quick_res;
        end else if (WR_EN_I) begin
            gpr_q[WR_SEL_I] <= WR_DATA_I;
        end
    end

    // Wide product register.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            prod_q <= 32'h0000_0000;
        end else if (mul_done && !mul_imm_q) begin
            prod_q <= work_q;
        end else if (shift_done && skind_q == SK_WIDE) begin
            prod_q <= shift_final;
        end
    end

    // Condition register.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cond_q <= COND_RESET;
        end else if (mul_done || shift_done) begin
            // Done bit marks a valid result.
            cond_q[OPERATION_COMPLETE_BIT_BIT] <= 1'b1;
            if (shift_done && cnt_q != 6'h00) begin
                cond_q[SHIFT_OUT_BIT] <= step_out;
            end
        end else if (issue) begin
            unique case (OP_CODE_I)
                MCALU_SET_MODE: cond_q[MODE_HI_BIT:MODE_LO_BIT] <= MODE_I;
                MCALU_ADD, MCALU_ADDI, MCALU_SUB, MCALU_SUBI: begin
                    cond_q[CARRY_BIT] <= carry;
                    cond_q[ZERO_BIT] <= (addsub_res == 16'h0000);
                    cond_q[SIGN_BIT] <= addsub_res[DATA_W-1];
                    cond_q[UNSIGNED_LOW_BIT] <= u_low;
                    cond_q[UNSIGNED_HIGH_BIT] <= u_high;
                    cond_q[SIGNED_LOW_BIT] <= s_low;
                    cond_q[SIGNED_HIGH_BIT] <= s_high;
                end
                MCALU_TOINT: cond_q[SIGN_CONV_BIT] <= new_sign;
                MCALU_NOT, MCALU_AND, MCALU_OR, MCALU_XOR: begin
                    cond_q[MASK_MIN_BIT] <= (quick_res == 16'h0000);
                    cond_q[MASK_MAX_BIT] <= (quick_res == 16'hFFFF);
                end
                default: begin
                    if (is_shift || OP_CODE_I == MCALU_MUL ||
                            OP_CODE_I == MCALU_MULI) begin
                        cond_q[OPERATION_COMPLETE_BIT_BIT] <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Registered outputs.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_q <= 16'h0000;
        end else begin
            rd_q <= gpr_q[RD_SEL_I];
        end
    end

    assign RD_DATA_O = rd_q;
    assign COND_O = cond_q;
    assign PROD_O = prod_q;
    assign BUSY_O = busy_q;
endmodule

`default_nettype wire

// ### core/mcalu_pkg.sv
// Shared constants and types of the microcore arithmetic logic unit.
package mcalu_pkg;
    localparam int DATA_W = 16;
    localparam int WIDE_W = 32;
    localparam int GPR_N = 8;
    localparam int SEL_W = 3;
    localparam int IMM_W = 5;
    localparam int ADD_IMM_W = 4;
    localparam int CNT_W = 6;
    localparam logic [5:0] MUL_CYCLES = 6'h20;
    localparam logic [2:0] PROD_HI_GPR = 3'h6;
    localparam logic [2:0] PROD_LO_GPR = 3'h7;
    localparam logic [2:0] MASK_GPR = 3'h5;
    localparam logic [15:0] COND_RESET = 16'h0000;
    localparam logic [15:0] SIGNED_MAX = 16'h7FFF;
    localparam logic [15:0] SIGNED_MIN = 16'h8000;
    localparam logic [15:0] UNSIGNED_MAX = 16'hFFFF;
    localparam logic [15:0] UNSIGNED_MIN = 16'h0000;
    localparam int SHIFT_OUT_BIT = 15;
    localparam int SIGN_CONV_BIT = 14;
    localparam int CARRY_BIT = 13;
    localparam int MODE_HI_BIT = 12;
    localparam int MODE_LO_BIT = 11;
    localparam int MASK_MIN_BIT = 10;
    localparam int MASK_MAX_BIT = 9;
    localparam int ZERO_BIT = 6;
    localparam int SIGN_BIT = 5;
    localparam int UNSIGNED_LOW_BIT = 4;
    localparam int UNSIGNED_HIGH_BIT = 3;
    localparam int SIGNED_LOW_BIT = 2;
    localparam int SIGNED_HIGH_BIT = 1;
    localparam int OPERATION_COMPLETE_BIT_BIT = 0;

    typedef enum logic [1:0] {
        MCALU_SIGNED_WRAP = 2'h0,
        MCALU_SIGNED_CLAMP = 2'h1,
        MCALU_UNSIGNED_WRAP = 2'h2,
        MCALU_UNSIGNED_CLAMP = 2'h3
    } mcalu_mode_t;

    typedef enum logic [4:0] {
        MCALU_NOP, MCALU_SET_MODE, MCALU_ADD, MCALU_ADDI, MCALU_SUB,
        MCALU_SUBI, MCALU_MUL, MCALU_MULI, MCALU_TOINT, MCALU_APPLY_SIGN,
        MCALU_SHR, MCALU_SHRI, MCALU_SHL, MCALU_SHLI, MCALU_SHRS,
        MCALU_SHRSI, MCALU_SHLS, MCALU_SHLSI, MCALU_WSHR, MCALU_WSHRI,
        MCALU_WSHL, MCALU_WSHLI, MCALU_SHR8, MCALU_SHL8, MCALU_SWAP,
        MCALU_NOT, MCALU_AND, MCALU_OR, MCALU_XOR
    } mcalu_op_t;
endpackage

// ### verification/mcalu_core_properties.sv
// Concurrent checks on the ports of the arithmetic unit.
`timescale 1ns/1ps
`default_nettype none

module mcalu_core_properties
    import mcalu_pkg::*;
#(
    parameter int MUL_LATENCY = 32
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic OP_VALID_I,
    input wire mcalu_op_t OP_CODE_I,
    input wire logic [IMM_W-1:0] IMM_I,
    input wire logic [1:0] MODE_I,
    input wire logic [DATA_W-1:0] COND_O,
    input wire logic BUSY_O
);
    localparam int MUL_M1 = MUL_LATENCY - 1;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    wire logic take = OP_VALID_I && !BUSY_O;

    sequence s_mul_run;
        ##1 !COND_O[OPERATION_COMPLETE_BIT_BIT] ##MUL_M1 !COND_O[OPERATION_COMPLETE_BIT_BIT]
        ##1 COND_O[OPERATION_COMPLETE_BIT_BIT];
    endsequence

    sequence s_shift3_run;
        BUSY_O [*3] ##1 (!BUSY_O && COND_O[OPERATION_COMPLETE_BIT_BIT]);
    endsequence

    a_add_single_cycle: assert property (
        take && OP_CODE_I inside {MCALU_ADD, MCALU_ADDI, MCALU_SUB, MCALU_SUBI}
        |=> !BUSY_O) else $error("add or sub left the unit busy");
    a_mode_field_write: assert property (
        take && OP_CODE_I == MCALU_SET_MODE
        |=> COND_O[MODE_HI_BIT:MODE_LO_BIT] == $past(MODE_I))
        else $error("mode field not written");
    a_mode_field_kept: assert property (
        take && OP_CODE_I inside {MCALU_ADD, MCALU_ADDI, MCALU_SUB, MCALU_SUBI}
        |=> $stable(COND_O[MODE_HI_BIT:MODE_LO_BIT]))
        else $error("mode field changed by arithmetic");
    a_mul_done_timing: assert property (
        take && OP_CODE_I == MCALU_MUL |-> s_mul_run)
        else $error("multiply done at wrong cycle");
    a_shift_count_three: assert property (
        take && OP_CODE_I == MCALU_SHLI && IMM_I == 5'h03 |=> s_shift3_run)
        else $error("three position shift took wrong time");
    a_fixed_no_flags: assert property (
        take && OP_CODE_I inside {MCALU_SHR8, MCALU_SHL8, MCALU_SWAP}
        |=> COND_O == $past(COND_O) && !BUSY_O)
        else $error("byte move changed flags or stalled");
    a_logic_one_cycle: assert property (
        take && OP_CODE_I inside {MCALU_NOT, MCALU_AND, MCALU_OR, MCALU_XOR}
        |=> !BUSY_O) else $error("logic op left the unit busy");
    a_done_after_busy: assert property (
        $rose(COND_O[OPERATION_COMPLETE_BIT_BIT]) |-> $past(BUSY_O))
        else $error("done bit rose without a running operation");
endmodule

bind mcalu_core mcalu_core_properties #(.MUL_LATENCY(MUL_LATENCY)) u_props (
    .CLK_I(CLK_I), .RST_I(RST_I), .OP_VALID_I(OP_VALID_I),
    .OP_CODE_I(OP_CODE_I), .IMM_I(IMM_I), .MODE_I(MODE_I),
    .COND_O(COND_O), .BUSY_O(BUSY_O)
);

`default_nettype wire

// ### verification/mcalu_seq_model.sv
// Sequencer model that loads, issues and reads back unit operations.
`timescale 1ns/1ps
`default_nettype none

module mcalu_seq_model
    import mcalu_pkg::*;
(
    input wire logic clk_i,
    input wire logic busy_i,
    input wire logic [DATA_W-1:0] rd_data_i,
    output logic op_valid_o,
    output var mcalu_op_t op_code_o,
    output logic [SEL_W-1:0] op1_sel_o,
    output logic [SEL_W-1:0] op2_sel_o,
    output logic [SEL_W-1:0] res_sel_o,
    output logic [IMM_W-1:0] imm_o,
    output logic [1:0] mode_o,
    output logic accum_o,
    output logic wr_en_o,
    output logic [SEL_W-1:0] wr_sel_o,
    output logic [DATA_W-1:0] wr_data_o,
    output logic [SEL_W-1:0] rd_sel_o
);
    initial begin
        op_valid_o = 1'b0;
        wr_en_o = 1'b0;
        op_code_o = MCALU_NOP;
        {op1_sel_o, op2_sel_o, res_sel_o, imm_o, mode_o, accum_o} = '0;
        {wr_sel_o, wr_data_o, rd_sel_o} = '0;
    end

    // Released select and immediate fields are inverted so stale values never pass as fresh; mode and accum keep their values.
    task automatic op(input mcalu_op_t c, input logic [8:0] sel,
                      input logic [4:0] im, input logic [2:0] ma);
        int n;
        @(negedge clk_i);
        op_valid_o = 1'b1;
        op_code_o = c;
        {op1_sel_o, op2_sel_o, res_sel_o} = sel;
        imm_o = im;
        {mode_o, accum_o} = ma;
        @(negedge clk_i);
        op_valid_o = 1'b0;
        {op1_sel_o, op2_sel_o} = ~{op1_sel_o, op2_sel_o};
        {res_sel_o, imm_o} = ~{res_sel_o, imm_o};
        n = 0;
        // A new operation is offered once the unit is idle again, or after 200 cycles of waiting.
        while (busy_i !== 1'b0 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
    endtask

    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        @(negedge clk_i);
        wr_en_o = 1'b1;
        wr_sel_o = s;
        wr_data_o = d;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        wr_data_o = ~wr_data_o;
    endtask

    task automatic rd(input logic [2:0] s, output logic [15:0] d);
        @(negedge clk_i);
        rd_sel_o = s;
        @(negedge clk_i);
        d = rd_data_i;
    endtask
endmodule

`default_nettype wire

// ### verification/mcalu_core_tb_top.sv
// Self-checking testbench of the arithmetic unit.
`timescale 1ns/1ps
`default_nettype none

module mcalu_core_tb_top;
    import mcalu_pkg::*;
    localparam int MUL_LAT = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic op_valid, accum, wen, busy;
    mcalu_op_t op_code;
    logic [2:0] s1, s2, rs, wsel, rsel;
    logic [4:0] imm;
    logic [1:0] mode;
    logic [15:0] wdata, rdata, cond;
    logic [31:0] prod;
    int n_errors = 0;
    int num_checks = 0;

    always #4 clk = ~clk;

    mcalu_core #(.MUL_LATENCY(MUL_LAT)) uut (
        .CLK_I(clk), .RST_I(rst), .OP_VALID_I(op_valid), .OP_CODE_I(op_code),
        .OP1_SEL_I(s1), .OP2_SEL_I(s2), .RES_SEL_I(rs), .IMM_I(imm),
        .MODE_I(mode), .ACCUM_SIGN_I(accum), .WR_EN_I(wen), .WR_SEL_I(wsel),
        .WR_DATA_I(wdata), .RD_SEL_I(rsel), .RD_DATA_O(rdata),
        .COND_O(cond), .PROD_O(prod), .BUSY_O(busy)
    );

    mcalu_seq_model seq (
        .clk_i(clk), .busy_i(busy), .rd_data_i(rdata), .op_valid_o(op_valid),
        .op_code_o(op_code), .op1_sel_o(s1), .op2_sel_o(s2), .res_sel_o(rs),
        .imm_o(imm), .mode_o(mode), .accum_o(accum), .wr_en_o(wen),
        .wr_sel_o(wsel), .wr_data_o(wdata), .rd_sel_o(rsel)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ar(input logic [1:0] md, input mcalu_op_t c,
                      input logic [15:0] a, b, e, input int bi,
                      input logic bv);
        logic [15:0] d;
        seq.wr(3'h1, a);
        seq.wr(3'h2, b);
        seq.op(MCALU_SET_MODE, 9'h000, 5'h00, {md, 1'b0});
        seq.op(c, {3'h1, 3'h2, 3'h3}, b[4:0], 3'h0);
        seq.rd(3'h3, d);
        chk(d, e);
        chk(cond[bi], bv);
        chk(cond[MODE_HI_BIT:MODE_LO_BIT], md);
    endtask

    task automatic one(input mcalu_op_t c, input logic [15:0] a,
                       input logic [4:0] im, input logic ac,
                       input logic [15:0] e);
        logic [15:0] d;
        seq.wr(3'h1, a);
        seq.op(c, {3'h1, 3'h2, 3'h3}, im, {2'h0, ac});
        chk(busy, 1'b0);
        seq.rd(3'h1, d);
        chk(d, e);
    endtask

    task automatic tm();
        logic [15:0] d;
        seq.wr(3'h1, 16'hFFFF);
        seq.op(MCALU_MUL, {3'h1, 3'h1, 3'h0}, 5'h00, 3'h0);
        chk(prod, 32'hFFFE_0001);
        chk(cond[OPERATION_COMPLETE_BIT_BIT], 1'b1);
        seq.wr(3'h4, 16'h0008);
        seq.op(MCALU_WSHLI, 9'h000, 5'h04, 3'h0);
        chk(prod, 32'hFFE0_0010);
        seq.op(MCALU_WSHR, {3'h4, 6'h00}, 5'h00, 3'h0);
        chk(prod, 32'h00FF_E000);
        seq.op(MCALU_WSHL, {3'h4, 6'h00}, 5'h00, 3'h0);
        chk(prod, 32'hFFE0_0000);
        seq.op(MCALU_WSHRI, 9'h000, 5'h14, 3'h0);
        chk(prod, 32'h0000_0FFE);
        seq.wr(3'h1, 16'h1234);
        seq.op(MCALU_MULI, {3'h1, 6'h00}, 5'h13, 3'h0);
        seq.rd(PROD_HI_GPR, d);
        chk(d, 16'h0001);
        seq.rd(PROD_LO_GPR, d);
        chk(d, 16'h59DC);
    endtask

    task automatic results();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        results();
    end

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk(cond, COND_RESET);
        chk(busy, 1'b0);
        ar(2'h0, MCALU_ADD, 16'h7FFF, 16'h0001, 16'h8000, 1, 1);
        ar(2'h1, MCALU_ADD, 16'h7FFF, 16'h0001, 16'h7FFF, 1, 1);
        ar(2'h1, MCALU_SUB, 16'h8000, 16'h0001, 16'h8000, 2, 1);
        ar(2'h0, MCALU_SUB, 16'h8000, 16'h0001, 16'h7FFF, 2, 1);
        ar(2'h2, MCALU_ADD, 16'hFFFF, 16'h0002, 16'h0001, 13, 1);
        ar(2'h2, MCALU_SUB, 16'h0001, 16'h0002, 16'hFFFF, 4, 1);
        ar(2'h3, MCALU_ADD, 16'hFFFF, 16'h0002, 16'hFFFF, 3, 1);
        ar(2'h3, MCALU_SUBI, 16'h0000, 16'h0011, 16'h0000, 4, 1);
        ar(2'h2, MCALU_ADDI, 16'h0010, 16'h001F, 16'h001F, 6, 0);
        ar(2'h0, MCALU_SUB, 16'h1234, 16'h1234, 16'h0000, 6, 1);
        tm();
        seq.wr(3'h2, 16'h0004);
        seq.wr(MASK_GPR, 16'h0FF0);
        one(MCALU_SHLI, 16'h00F1, 5'h03, 0, 16'h0788);
        chk(cond[OPERATION_COMPLETE_BIT_BIT], 1'b1);
        one(MCALU_SHRI, 16'h8001, 5'h01, 0, 16'h4000);
        chk(cond[SHIFT_OUT_BIT], 1'b1);
        one(MCALU_SHR, 16'hF000, 5'h00, 0, 16'h0F00);
        one(MCALU_SHL, 16'h000F, 5'h00, 0, 16'h00F0);
        one(MCALU_SHRSI, 16'h8010, 5'h02, 0, 16'hE004);
        one(MCALU_SHLSI, 16'hC001, 5'h01, 0, 16'h8002);
        one(MCALU_SHRS, 16'h8100, 5'h00, 0, 16'hF810);
        one(MCALU_SHLS, 16'h8421, 5'h00, 0, 16'hC210);
        one(MCALU_SHR8, 16'h12A5, 5'h00, 0, 16'h0012);
        one(MCALU_SHL8, 16'h12A5, 5'h00, 0, 16'hA500);
        one(MCALU_SWAP, 16'h12A5, 5'h00, 0, 16'hA512);
        one(MCALU_AND, 16'h3C3C, 5'h00, 0, 16'h0C30);
        one(MCALU_OR, 16'h3C3C, 5'h00, 0, 16'h3FFC);
        one(MCALU_XOR, 16'h3C3C, 5'h00, 0, 16'h33CC);
        one(MCALU_NOT, 16'h3C3C, 5'h00, 0, 16'hC3C3);
        one(MCALU_TOINT, 16'hFFFB, 5'h00, 0, 16'h0005);
        chk(cond[SIGN_CONV_BIT], 1'b1);
        one(MCALU_APPLY_SIGN, 16'h0005, 5'h00, 0, 16'hFFFB);
        one(MCALU_TOINT, 16'hFFFE, 5'h00, 1, 16'h0002);
        chk(cond[SIGN_CONV_BIT], 1'b0);
        one(MCALU_APPLY_SIGN, 16'h0002, 5'h00, 0, 16'h0002);
        results();
    end
endmodule

`default_nettype wire
